/* include/rx_cfg_params.svh */
// Register map, field positions, reset values and timing counts of the receiver config bank
`ifndef RX_CFG_PARAMS_SVH
`define RX_CFG_PARAMS_SVH

`define ADDR_FIFO 7'h00
`define ADDR_OPMODE 7'h01
`define ADDR_DATAMOD 7'h02
`define ADDR_DIV_HIGH 7'h03
`define ADDR_DIV_LOW 7'h04
`define ADDR_RSVD5 7'h05
`define ADDR_RSVD6 7'h06
`define ADDR_CARR_HIGH 7'h07
`define ADDR_CARR_MID 7'h08
`define ADDR_CARR_LOW 7'h09
`define ADDR_KEY_FIRST 7'h3E
`define ADDR_KEY_LAST 7'h4D
`define ADDR_TEMP_CTRL 7'h4E
`define ADDR_TEMP_READ 7'h4F
`define ADDR_SENS_BOOST 7'h58
`define ADDR_FADE_GAIN 7'h6F
`define ADDR_FREQ_OFFSET 7'h71

`define OP_BYPASS_BIT 7
`define OP_WATCH_EN_BIT 6
`define OP_WATCH_CANCEL_BIT 5
`define MODE_SLEEP 3'h0
`define MODE_STANDBY 3'h1
`define MODE_SYNTH 3'h2
`define MODE_RX 3'h4
`define DP_PACKET 2'h0
`define DP_RESERVED 2'h1
`define MOD_FSK 2'h0
`define MOD_OOK 2'h1

`define RST_DIV_HIGH 8'h1A
`define RST_DIV_LOW 8'h0B
`define RST_CARR_HIGH 8'hE4
`define RST_CARR_MID 8'hC0
`define RST_CARR_LOW 8'h00
`define RST_RSVD5 8'h00
`define RST_RSVD6 8'h52
`define RST_TEMP_CTRL 8'h01
`define RST_SENS_BOOST 8'h1B
`define RST_FADE_GAIN 8'h00
`define RST_FREQ_OFFSET 8'h00
`define RST_KEY_BYTE 8'h00

`define CLK_PERIOD_NS 50
`define MODE_STEP_NS 1000
`define MODE_STEP_CYCLES ((`MODE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* include/rx_cfg_pkg.sv */
// Types shared by the receiver config bank and its serial port
package rx_cfg_pkg;
  typedef logic [7:0] byte_type;
  typedef logic [6:0] reg_addr_type;
  typedef logic [2:0] mode_code_type;
  typedef enum {SEQ_HOLD, SEQ_SETTLE} seq_state_type;
endpackage

/* logic/spi_byte_port.sv */
// Serial register port: address byte then data bytes with address auto-increment
`timescale 1ns/1ns
module spi_byte_port
  import rx_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic sck,
  input wire logic nss_n,
  input wire logic mosi,
  input wire rx_cfg_pkg::byte_type rdata,
  output logic miso,
  output logic miso_oe,
  output rx_cfg_pkg::reg_addr_type rd_addr,
  output logic wr_stb,
  output rx_cfg_pkg::reg_addr_type wr_addr,
  output rx_cfg_pkg::byte_type wr_data
);
  import rx_cfg_pkg::*;

  logic sck_q;
  logic [2:0] bit_cnt;
  logic first;
  logic wnr;
  logic load_pend;
  logic [6:0] sh_in;
  byte_type sh_out;
  logic rise;
  logic fall;
  byte_type next_byte;

  assign rise = sck & ~sck_q;
  assign fall = ~sck & sck_q;
  assign next_byte = {sh_in, mosi};

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      sck_q <= 1'b0;
    else if (ce)
      sck_q <= sck;
  end

  // Receive side: SCK must be slower than a few core cycles per half period
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt <= 3'h0;
      first <= 1'b1;
      wnr <= 1'b0;
      load_pend <= 1'b0;
      sh_in <= 7'h00;
      rd_addr <= 7'h00;
      wr_stb <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
    end
    else if (ce)
    begin
      wr_stb <= 1'b0;
      if (nss_n)
      begin
        bit_cnt <= 3'h0;
        first <= 1'b1;
        load_pend <= 1'b0;
      end
      else
      begin
        if (fall)
          load_pend <= 1'b0;
        if (rise)
        begin
          sh_in <= next_byte[6:0];
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7)
          begin
            if (first)
            begin
              first <= 1'b0;
              wnr <= next_byte[7];
              rd_addr <= next_byte[6:0];
              load_pend <= ~next_byte[7];
            end
            else
            begin
              wr_stb <= wnr;
              wr_addr <= rd_addr;
              wr_data <= next_byte;
              rd_addr <= rd_addr + 7'h01;
              load_pend <= ~wnr;
            end
          end
        end
      end
    end
  end

  // Transmit side: the byte is fetched on the falling edge after the address settles
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_out <= 8'h00;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end
    else if (ce)
    begin
      miso_oe <= ~nss_n;
      if (!nss_n && fall)
      begin
        if (load_pend)
        begin
          miso <= rdata[7];
          sh_out <= {rdata[6:0], 1'b0};
        end
        else
        begin
          miso <= sh_out[7];
          sh_out <= {sh_out[6:0], 1'b0};
        end
      end
    end
  end
endmodule

/* logic/radio_rx_common_config_regs.sv */
// Common configuration register bank of the receiver with mode sequencer and bit-rate tick
`timescale 1ns/1ns
`include "rx_cfg_params.svh"
module radio_rx_common_config_regs
  import rx_cfg_pkg::*;
#(
  parameter int STEP_CYCLES = `MODE_STEP_CYCLES
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic spi_sck,
  input wire logic spi_nss_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  output rx_cfg_pkg::mode_code_type chip_mode,
  output logic duty_cycle_watch_active,
  output logic [1:0] data_processing_select,
  output logic [1:0] modulation_select,
  output logic [15:0] bit_period_divisor,
  output logic [23:0] carrier_word,
  output logic [127:0] cipher_key,
  output logic bit_tick
);
  import rx_cfg_pkg::*;

  logic rst_meta;
  logic rst_n;
  logic wr_stb;
  reg_addr_type wr_addr;
  reg_addr_type rd_addr;
  byte_type wr_data;
  byte_type rdata;
  byte_type opmode_rd;
  logic sequencer_bypass;
  logic duty_cycle_watch_enable;
  mode_code_type target_mode;
  seq_state_type seq_state;
  logic [15:0] step_cnt;
  logic [15:0] tick_cnt;
  byte_type key_mem [16];
  byte_type temp_ctrl;
  byte_type sens_boost;
  byte_type fade_gain;
  byte_type freq_offset;

  // Rank of a legal mode along the sleep-standby-synth-receive chain
  function automatic logic [1:0] mode_rank(input mode_code_type code);
    logic [1:0] r;
    r = 2'h1;
    case (code)
      `MODE_SLEEP: r = 2'h0;
      `MODE_SYNTH: r = 2'h2;
      `MODE_RX: r = 2'h3;
      default: r = 2'h1;
    endcase
    return r;
  endfunction

  function automatic mode_code_type rank_mode(input logic [1:0] rank);
    mode_code_type c;
    c = `MODE_STANDBY;
    case (rank)
      2'h0: c = `MODE_SLEEP;
      2'h2: c = `MODE_SYNTH;
      2'h3: c = `MODE_RX;
      default: c = `MODE_STANDBY;
    endcase
    return c;
  endfunction

  function automatic logic mode_legal(input mode_code_type code);
    return code == `MODE_SLEEP || code == `MODE_STANDBY || code == `MODE_SYNTH
      || code == `MODE_RX;
  endfunction

  function automatic logic key_hit(input reg_addr_type a);
    return a >= `ADDR_KEY_FIRST && a <= `ADDR_KEY_LAST;
  endfunction

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  spi_byte_port port_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .sck(spi_sck),
    .nss_n(spi_nss_n),
    .mosi(spi_mosi),
    .rdata(rdata),
    .miso(spi_miso),
    .miso_oe(spi_miso_oe),
    .rd_addr(rd_addr),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // Cancel bit and unused low bits are never stored
  assign opmode_rd = {sequencer_bypass, duty_cycle_watch_enable, 1'b0, chip_mode, 2'b00};

  always_comb
  begin
    rdata = 8'h00;
    if (key_hit(rd_addr))
      rdata = key_mem[4'(rd_addr - `ADDR_KEY_FIRST)];
    else
    begin
      case (rd_addr)
        `ADDR_OPMODE: rdata = opmode_rd;
        `ADDR_DATAMOD: rdata = {1'b0, data_processing_select, modulation_select, 3'b000};
        `ADDR_DIV_HIGH: rdata = bit_period_divisor[15:8];
        `ADDR_DIV_LOW: rdata = bit_period_divisor[7:0];
        `ADDR_RSVD5: rdata = `RST_RSVD5;
        `ADDR_RSVD6: rdata = `RST_RSVD6;
        `ADDR_CARR_HIGH: rdata = carrier_word[23:16];
        `ADDR_CARR_MID: rdata = carrier_word[15:8];
        `ADDR_CARR_LOW: rdata = carrier_word[7:0];
        `ADDR_TEMP_CTRL: rdata = temp_ctrl;
        `ADDR_SENS_BOOST: rdata = sens_boost;
        `ADDR_FADE_GAIN: rdata = fade_gain;
        `ADDR_FREQ_OFFSET: rdata = freq_offset;
        default: rdata = 8'h00;
      endcase
    end
  end

  // Operating mode control register and watch state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sequencer_bypass <= 1'b0;
      duty_cycle_watch_enable <= 1'b0;
      duty_cycle_watch_active <= 1'b0;
      target_mode <= `MODE_STANDBY;
    end
    else if (ce && wr_stb && wr_addr == `ADDR_OPMODE)
    begin
      sequencer_bypass <= wr_data[`OP_BYPASS_BIT];
      duty_cycle_watch_enable <= wr_data[`OP_WATCH_EN_BIT];
      // Clearing the enable alone leaves the watch running until cancelled
      if (wr_data[`OP_WATCH_EN_BIT])
        duty_cycle_watch_active <= 1'b1;
      else if (wr_data[`OP_WATCH_CANCEL_BIT])
        duty_cycle_watch_active <= 1'b0;
      if (mode_legal(wr_data[4:2]))
        target_mode <= wr_data[4:2];
    end
  end

  // Mode sequencer; the actual mode is what the host reads back
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chip_mode <= `MODE_STANDBY;
      seq_state <= SEQ_HOLD;
      step_cnt <= 16'h0000;
    end
    else if (ce)
    begin
      if (sequencer_bypass)
      begin
        chip_mode <= target_mode;
        seq_state <= SEQ_HOLD;
        step_cnt <= 16'h0000;
      end
      else
      begin
        unique case (seq_state)
          SEQ_HOLD:
            if (chip_mode != target_mode)
            begin
              seq_state <= SEQ_SETTLE;
              step_cnt <= 16'h0000;
            end
          SEQ_SETTLE:
            if (chip_mode == target_mode)
              seq_state <= SEQ_HOLD;
            else if (step_cnt == 16'(STEP_CYCLES - 1))
            begin
              // Step one rank per settle period toward the request
              step_cnt <= 16'h0000;
              if (mode_rank(target_mode) > mode_rank(chip_mode))
                chip_mode <= rank_mode(mode_rank(chip_mode) + 2'h1);
              else
                chip_mode <= rank_mode(mode_rank(chip_mode) - 2'h1);
            end
            else
              step_cnt <= step_cnt + 16'h0001;
        endcase
      end
    end
  end

  // Data path configuration, divisor and carrier word
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_processing_select <= `DP_PACKET;
      modulation_select <= `MOD_FSK;
      bit_period_divisor <= {`RST_DIV_HIGH, `RST_DIV_LOW};
      carrier_word <= {`RST_CARR_HIGH, `RST_CARR_MID, `RST_CARR_LOW};
    end
    else if (ce && wr_stb)
    begin
      unique case (wr_addr)
        `ADDR_DATAMOD:
        begin
          // Reserved codes are refused and the old selection kept
          if (wr_data[6:5] != `DP_RESERVED)
            data_processing_select <= wr_data[6:5];
          if (!wr_data[4])
            modulation_select <= wr_data[4:3];
        end
        `ADDR_DIV_HIGH: bit_period_divisor[15:8] <= wr_data;
        `ADDR_DIV_LOW: bit_period_divisor[7:0] <= wr_data;
        `ADDR_CARR_HIGH: carrier_word[23:16] <= wr_data;
        `ADDR_CARR_MID: carrier_word[15:8] <= wr_data;
        `ADDR_CARR_LOW: carrier_word[7:0] <= wr_data;
        default:
        begin
        end
      endcase
    end
  end

  // Cipher key and trailing test registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 16; i++)
        key_mem[i] <= `RST_KEY_BYTE;
      temp_ctrl <= `RST_TEMP_CTRL;
      sens_boost <= `RST_SENS_BOOST;
      fade_gain <= `RST_FADE_GAIN;
      freq_offset <= `RST_FREQ_OFFSET;
    end
    else if (ce && wr_stb)
    begin
      if (key_hit(wr_addr))
        key_mem[4'(wr_addr - `ADDR_KEY_FIRST)] <= wr_data;
      if (wr_addr == `ADDR_TEMP_CTRL)
        temp_ctrl <= wr_data;
      if (wr_addr == `ADDR_SENS_BOOST)
        sens_boost <= wr_data;
      if (wr_addr == `ADDR_FADE_GAIN)
        fade_gain <= wr_data;
      if (wr_addr == `ADDR_FREQ_OFFSET)
        freq_offset <= wr_data;
    end
  end

  // First key register lands in the top byte of the key
  always_comb
  begin
    for (int i = 0; i < 16; i++)
      cipher_key[127 - 8 * i -: 8] = key_mem[i];
  end

  // Core clock stands in for the crystal; a zero divisor behaves as one
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt <= 16'h0000;
      bit_tick <= 1'b0;
    end
    else if (ce)
    begin
      if (tick_cnt + 16'h0001 >= bit_period_divisor)
      begin
        tick_cnt <= 16'h0000;
        bit_tick <= 1'b1;
      end
      else
      begin
        tick_cnt <= tick_cnt + 16'h0001;
        bit_tick <= 1'b0;
      end
    end
  end

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_cancel_reads_zero:
    assert property (rd_addr == `ADDR_OPMODE |-> rdata[`OP_WATCH_CANCEL_BIT] == 1'b0)
    else $error("cancel bit read back as one");

  a_bypass_applies_direct:
    assert property (ce && sequencer_bypass |=> chip_mode == $past(target_mode))
    else $error("bypassed mode not applied at once");

  a_sequencer_single_step:
    assert property (ce && !sequencer_bypass && chip_mode != target_mode
      && seq_state == SEQ_SETTLE && step_cnt == 16'(STEP_CYCLES - 1)
      |=> (mode_rank(chip_mode) == mode_rank($past(chip_mode)) + 2'h1)
      || (mode_rank(chip_mode) == mode_rank($past(chip_mode)) - 2'h1))
    else $error("sequencer skipped a mode");

  a_mode_code_legal:
    assert property (mode_legal(chip_mode) && mode_legal(target_mode))
    else $error("reserved mode code reached");

  a_mode_reads_actual:
    assert property (rd_addr == `ADDR_OPMODE |-> rdata[4:2] == chip_mode)
    else $error("mode field does not show actual mode");

  a_data_processing_select_not_reserved:
    assert property (data_processing_select != `DP_RESERVED)
    else $error("reserved data processing code stored");

  a_tick_wraps_count:
    assert property (ce && bit_tick && bit_period_divisor > 16'h0001 |-> tick_cnt == 16'h0000
      ##1 (!ce || !bit_tick))
    else $error("bit tick not spaced by divisor");

  a_carrier_mid_write:
    assert property (ce && wr_stb && wr_addr == `ADDR_CARR_MID
      |=> carrier_word[15:8] == $past(wr_data))
    else $error("middle carrier byte not written");

  a_key_byte_write:
    assert property (ce && wr_stb && wr_addr == `ADDR_KEY_FIRST
      |=> cipher_key[127:120] == $past(wr_data))
    else $error("first key byte not written");

  a_reserved_fixed:
    assert property (rd_addr == `ADDR_RSVD6 |-> rdata == `RST_RSVD6)
    else $error("reserved register value changed");
endmodule

/* verification/spi_host_model.sv */
// Host-side serial master issuing one command byte and one data byte per select frame
`timescale 1ns/1ns
module spi_host_model
  import rx_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic miso,
  output logic sck,
  output logic nss_n,
  output logic mosi
);
  initial
  begin
    sck = 1'b0;
    nss_n = 1'b1;
    mosi = 1'b0;
  end

  // Four core cycles per half period keeps the synchronous edge detector safe
  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask

  // Whole frame in one select, so a cancel and its new mode land together
  task automatic xfer(input logic wr, input reg_addr_type addr, input byte_type wdata,
    output byte_type rdata);
    logic [15:0] frame;
    frame = {wr, addr, wdata};
    rdata = 8'h00;
    @(negedge core_clk);
    nss_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      mosi = frame[i];
      half();
      rdata = {rdata[6:0], miso};
      sck = 1'b1;
      half();
      sck = 1'b0;
    end
    half();
    nss_n = 1'b1;
    // Released data line flips so a stale bit never looks valid
    mosi = ~mosi;
    half();
  endtask
endmodule

/* verification/testbench.sv */
// Self-checking bench for the receiver common configuration bank
`timescale 1ns/1ns
`include "rx_cfg_params.svh"
module testbench
  import rx_cfg_pkg::*;
;
  // Long enough that a read issued right after a mode request still sees the old mode
  localparam int STEPS = 100;
  logic core_clk;
  logic nrst;
  logic ce;
  logic sck;
  logic nss_n;
  logic mosi;
  logic spi_miso;
  logic spi_miso_oe;
  logic miso_line;
  logic miso_last = 1'b0;
  mode_code_type chip_mode;
  logic duty_cycle_watch_active;
  logic [1:0] data_processing_select;
  logic [1:0] modulation_select;
  logic [15:0] bit_period_divisor;
  logic [23:0] carrier_word;
  logic [127:0] cipher_key;
  logic bit_tick;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;

  radio_rx_common_config_regs #(.STEP_CYCLES(STEPS)) dut (
    .core_clk(core_clk), .nrst(nrst), .ce(ce), .spi_sck(sck), .spi_nss_n(nss_n),
    .spi_mosi(mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .chip_mode(chip_mode),
    .duty_cycle_watch_active(duty_cycle_watch_active),
    .data_processing_select(data_processing_select), .modulation_select(modulation_select),
    .bit_period_divisor(bit_period_divisor), .carrier_word(carrier_word),
    .cipher_key(cipher_key), .bit_tick(bit_tick));

  spi_host_model host (.core_clk(core_clk), .miso(miso_line), .sck(sck), .nss_n(nss_n),
    .mosi(mosi));

  // Undriven data line shows the opposite of its last driven level
  always @(posedge core_clk)
  begin
    if (spi_miso_oe === 1'b1)
      miso_last <= spi_miso;
  end
  assign miso_line = (spi_miso_oe === 1'b1) ? spi_miso : ~miso_last;

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wr(input reg_addr_type a, input byte_type d);
    byte_type junk;
    host.xfer(1'b1, a, d, junk);
  endtask

  task automatic rd_check(input string what, input reg_addr_type a, input byte_type exp);
    byte_type got;
    host.xfer(1'b0, a, 8'h00, got);
    check(what, exp, got);
  endtask

  task automatic t_reset_values();
    check("divisor", 16'h1A0B, bit_period_divisor);
    check("carrier", 24'hE4C000, carrier_word);
    check("key", 128'h0, cipher_key);
    check("mode", `MODE_STANDBY, chip_mode);
    rd_check("opmode", `ADDR_OPMODE, 8'h04);
    rd_check("datamod", `ADDR_DATAMOD, 8'h00);
    rd_check("div_hi", `ADDR_DIV_HIGH, 8'h1A);
    rd_check("div_lo", `ADDR_DIV_LOW, 8'h0B);
    rd_check("rsvd6", `ADDR_RSVD6, 8'h52);
    rd_check("carr_hi", `ADDR_CARR_HIGH, 8'hE4);
    rd_check("carr_mid", `ADDR_CARR_MID, 8'hC0);
    rd_check("key_last", `ADDR_KEY_LAST, 8'h00);
  endtask

  task automatic t_registers();
    wr(`ADDR_CARR_MID, 8'h5A);
    check("carrier_mid_out", 8'h5A, carrier_word[15:8]);
    rd_check("carrier_mid_rd", `ADDR_CARR_MID, 8'h5A);
    wr(`ADDR_KEY_FIRST, 8'hA5);
    wr(`ADDR_KEY_LAST, 8'h3C);
    check("key_first", 8'hA5, cipher_key[127:120]);
    check("key_last_out", 8'h3C, cipher_key[7:0]);
    wr(`ADDR_RSVD6, 8'hFF);
    rd_check("rsvd6_ro", `ADDR_RSVD6, 8'h52);
    wr(`ADDR_RSVD5, 8'hFF);
    rd_check("rsvd5_ro", `ADDR_RSVD5, 8'h00);
  endtask

  task automatic t_rate();
    int gap;
    wr(`ADDR_DIV_HIGH, 8'h00);
    wr(`ADDR_DIV_LOW, 8'h05);
    check("divisor_out", 16'h0005, bit_period_divisor);
    for (int i = 0; i < 20 && bit_tick !== 1'b1; i++)
      @(negedge core_clk);
    @(negedge core_clk);
    gap = 1;
    while (bit_tick !== 1'b1 && gap < 20)
    begin
      @(negedge core_clk);
      gap++;
    end
    check("tick_gap", 5, gap);
  endtask

  task automatic t_data_mode();
    byte_type val [4] = '{8'hC9, 8'h60, 8'h00, 8'hBF};
    logic [3:0] exp [4] = '{4'h9, 4'hC, 4'h0, 4'h0};
    for (int i = 0; i < 4; i++)
    begin
      wr(`ADDR_DATAMOD, val[i]);
      check("dp_mod", exp[i], {data_processing_select, modulation_select});
      rd_check("datamod_rd", `ADDR_DATAMOD, {1'b0, exp[i], 3'b000});
    end
    rd_check("datamod_fixed", `ADDR_DATAMOD, 8'h00);
  endtask

  task automatic t_forced_mode();
    mode_code_type code [5] = '{`MODE_SLEEP, `MODE_SYNTH, `MODE_RX, 3'h3, `MODE_STANDBY};
    mode_code_type exp [5] = '{`MODE_SLEEP, `MODE_SYNTH, `MODE_RX, `MODE_RX, `MODE_STANDBY};
    for (int i = 0; i < 5; i++)
    begin
      wr(`ADDR_OPMODE, {3'b100, code[i], 2'b11});
      check("forced_mode", exp[i], chip_mode);
      rd_check("forced_rd", `ADDR_OPMODE, {3'b100, exp[i], 2'b00});
    end
  endtask

  task automatic t_sequencer();
    logic saw_synth;
    saw_synth = 1'b0;
    wr(`ADDR_OPMODE, {3'b000, `MODE_RX, 2'b00});
    check("seq_start", `MODE_STANDBY, chip_mode);
    rd_check("seq_mid_rd", `ADDR_OPMODE, {3'b000, `MODE_STANDBY, 2'b00});
    for (int i = 0; i < 4 * STEPS && chip_mode !== `MODE_RX; i++)
    begin
      @(negedge core_clk);
      if (chip_mode === `MODE_SYNTH)
        saw_synth = 1'b1;
    end
    check("seq_via_synth", 1'b1, saw_synth);
    check("seq_end", `MODE_RX, chip_mode);
    rd_check("seq_rd", `ADDR_OPMODE, {3'b000, `MODE_RX, 2'b00});
  endtask

  task automatic t_watch();
    wr(`ADDR_OPMODE, {3'b110, `MODE_STANDBY, 2'b00});
    check("watch_on", 1'b1, duty_cycle_watch_active);
    rd_check("watch_rd", `ADDR_OPMODE, {3'b110, `MODE_STANDBY, 2'b00});
    wr(`ADDR_OPMODE, {3'b100, `MODE_STANDBY, 2'b00});
    check("watch_kept", 1'b1, duty_cycle_watch_active);
    wr(`ADDR_OPMODE, {3'b101, `MODE_RX, 2'b00});
    check("watch_off", 1'b0, duty_cycle_watch_active);
    check("watch_mode", `MODE_RX, chip_mode);
    rd_check("cancel_rd", `ADDR_OPMODE, {3'b100, `MODE_RX, 2'b00});
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      n_fail = n_fail + 1;
      report_and_stop();
    end
  end

  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    repeat (12) @(negedge core_clk);
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    t_reset_values();
    t_registers();
    t_rate();
    t_data_mode();
    t_forced_mode();
    t_sequencer();
    t_watch();
    nrst = 1'b0;
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    t_reset_values();
    report_and_stop();
  end
endmodule
